// ### cmp_map.svh
// Register offsets, field positions and reset values of the comparator control block
`ifndef CMP_MAP_SVH
`define CMP_MAP_SVH

`define CMP_ADDR_W         4
`define CMP_OFS_CTRL1      4'h0
`define CMP_OFS_CTRL2      4'h1
`define CMP_OFS_CTRL2B     4'h2
`define CMP_OFS_FLAGS      4'h3
`define CMP_OFS_ENABLES    4'h4
`define CMP_OFS_IRQCTL     4'h5
`define CMP_OFS_PINDIR     4'h6
`define CMP_OFS_PORTLAT    4'h7

`define CMP_CTRL_RST       8'h00
`define CMP_CTRL_WMASK     8'hB7
`define CMP_BIT_ON         7
`define CMP_BIT_OUT        6
`define CMP_BIT_OE         5
`define CMP_BIT_POL        4
`define CMP_BIT_REF        2
`define CMP_CH_HI          1
`define CMP_CH_LO          0

`define CMP_CTRL2B_RST     8'h00
`define CMP_CTRL2B_WMASK   8'h03
`define CMP_BIT_MIR1       7
`define CMP_BIT_MIR2       6

`define CMP_BIT_GIE        7
`define CMP_BIT_PERIPHERAL_IRQ_ENABLE       6

`define CMP_PHASES         2'h3
`define CMP_PHASE_COUNT    4
`define CMP_PINDIR_RST     2'h3

`endif

// ### cmp_pkg.sv
// Types shared by the comparator control block
package cmp_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [1:0] chan_t;
endpackage : cmp_pkg

// ### cmp_ctrl.sv
// Two-comparator control, pin gating and change-detect interrupt logic
//
// Operation
// - Raw result high when plus input higher
// - comparator_on enables, off gives lowest current
// - Two-bit field picks inverting input pin
// - reference_select routes internal reference to plus
// - Result readable in control and mirror register
// - Pin driven only if enabled, output, on
// - Output enable overrides port latch regardless
// - Internal result registered each instruction cycle
// - output_invert inverts the reported result
// - Snapshot latch captures result on control read
// - Second latch resamples on first phase
// - Mismatch is XOR of both latches
// - Mismatch holds until read or reversal
// - Control write refreshes snapshot, clears mismatch
// - Detection independent of output pin enable
// - Flag set by mismatch rising edge
// - After clearing, new change needed for irq
// - Flag cleared by writing 0, set by 1
// - Irq needs all three enables; flag regardless
// - Only second comparator feeds timer link
// - Reset clears control registers except pin direction (set to input), comparators off
// - Change wakes sleep with two enables
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`include "cmp_map.svh"

module cmp_ctrl #(
	parameter int PHASE_COUNT = 4
) (
	input  wire logic                    REF_CLK,
	input  wire logic                    RST,
	input  wire logic [`CMP_ADDR_W-1:0]  ADDR,
	input  wire cmp_pkg::byte_t          WDATA,
	input  wire logic                    WR,
	input  wire logic                    RD,
	output logic      [7:0]              RDATA,
	input  wire logic [1:0]              ANALOG_CMP,
	output logic      [1:0]              CMP_ENABLE,
	output cmp_pkg::chan_t               CMP1_CHAN,
	output cmp_pkg::chan_t               CMP2_CHAN,
	output logic      [1:0]              CMP_REF_SEL,
	output logic      [1:0]              PIN_OUT,
	output logic      [1:0]              PIN_OE_N,
	output logic                         TIMER_CMP,
	output logic      [1:0]              TIMER_LINK,
	output logic                         IRQ,
	output logic                         WAKE
);
	import cmp_pkg::*;

	// The phase counter and its wrap value serve only the four-phase instruction cycle
	generate
		if (PHASE_COUNT != `CMP_PHASE_COUNT)
		begin : g_bad_phase
			$error("PHASE_COUNT must equal the instruction cycle length");
		end
	endgenerate

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	byte_t       ctrl_q [2];
	byte_t       ctrl2b_q;
	logic  [1:0] flag_q;
	logic  [1:0] ien_q;
	logic        gie_q;
	logic        peripheral_irq_enable_q;
	logic  [1:0] pindir_q;
	logic  [1:0] portlat_q;
	logic  [1:0] phase_q;
	logic        first_clock_phase;
	logic  [1:0] result;
	logic  [1:0] snap_q;
	logic  [1:0] resample_q;
	logic  [1:0] mismatch;
	logic  [1:0] mismatch_q;
	logic  [1:0] ctrl_touch;
	logic  [1:0] comparator_output;

	// Phase zero stands for the first phase of each instruction cycle
	assign first_clock_phase = (phase_q == 2'h0);

	always_ff @(posedge REF_CLK)
	begin
		if (RST)
			phase_q <= 2'h0;
		else if (phase_q == `CMP_PHASES)
			phase_q <= 2'h0;
		else
			phase_q <= phase_q + 2'h1;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_cmp
			// Disabled comparator reads low; raw is high when plus above minus
			assign result[gi] = ctrl_q[gi][`CMP_BIT_ON] & (ANALOG_CMP[gi] ^ ctrl_q[gi][`CMP_BIT_POL]);
			assign comparator_output[gi] = resample_q[gi];
			// A write is read-modify-write, so it refreshes the snapshot too
			assign ctrl_touch[gi] = (RD | WR) && (ADDR == ((gi == 0) ? `CMP_OFS_CTRL1 : `CMP_OFS_CTRL2));

			always_ff @(posedge REF_CLK)
			begin
				if (RST)
					ctrl_q[gi] <= `CMP_CTRL_RST;
				else if (WR && ADDR == ((gi == 0) ? `CMP_OFS_CTRL1 : `CMP_OFS_CTRL2))
					ctrl_q[gi] <= WDATA & `CMP_CTRL_WMASK;
			end

			always_ff @(posedge REF_CLK)
			begin
				if (RST)
					snap_q[gi] <= 1'b0;
				// Capture what software reads, so a change not yet resampled raises no false edge
				else if (ctrl_touch[gi])
					snap_q[gi] <= comparator_output[gi];
			end

			always_ff @(posedge REF_CLK)
			begin
				if (RST)
					resample_q[gi] <= 1'b0;
				else if (first_clock_phase)
					resample_q[gi] <= result[gi];
			end

			// Read forces the mismatch low in that cycle
			assign mismatch[gi] = (snap_q[gi] ^ resample_q[gi]) & ~ctrl_touch[gi];

			always_ff @(posedge REF_CLK)
			begin
				if (RST)
					mismatch_q[gi] <= 1'b0;
				else
					mismatch_q[gi] <= mismatch[gi];
			end

			// Hardware set wins over a software write in the same cycle
			always_ff @(posedge REF_CLK)
			begin
				if (RST)
					flag_q[gi] <= 1'b0;
				else if (mismatch[gi] & ~mismatch_q[gi])
					flag_q[gi] <= 1'b1;
				else if (WR && ADDR == `CMP_OFS_FLAGS)
					flag_q[gi] <= WDATA[gi];
			end

			// Pin mux: output enable takes the pin from the comparator result
			always_ff @(posedge REF_CLK)
			begin
				if (RST)
				begin
					PIN_OUT[gi]  <= 1'b0;
					PIN_OE_N[gi] <= 1'b1;
				end
				else
				begin
					PIN_OUT[gi]  <= ctrl_q[gi][`CMP_BIT_OE] ? result[gi] : portlat_q[gi];
					PIN_OE_N[gi] <= pindir_q[gi] |
						(ctrl_q[gi][`CMP_BIT_OE] & ~ctrl_q[gi][`CMP_BIT_ON]);
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Shared control registers
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
			ctrl2b_q <= `CMP_CTRL2B_RST;
		else if (WR && ADDR == `CMP_OFS_CTRL2B)
			ctrl2b_q <= WDATA & `CMP_CTRL2B_WMASK;
	end

	always_ff @(posedge REF_CLK)
	begin
		if (RST)
			ien_q <= 2'h0;
		else if (WR && ADDR == `CMP_OFS_ENABLES)
			ien_q <= WDATA[1:0];
	end

	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			gie_q  <= 1'b0;
			peripheral_irq_enable_q <= 1'b0;
		end
		else if (WR && ADDR == `CMP_OFS_IRQCTL)
		begin
			gie_q  <= WDATA[`CMP_BIT_GIE];
			peripheral_irq_enable_q <= WDATA[`CMP_BIT_PERIPHERAL_IRQ_ENABLE];
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			pindir_q  <= `CMP_PINDIR_RST;
			portlat_q <= 2'h0;
		end
		else if (WR)
		begin
			if (ADDR == `CMP_OFS_PINDIR)
				pindir_q <= WDATA[1:0];
			if (ADDR == `CMP_OFS_PORTLAT)
				portlat_q <= WDATA[1:0];
		end
	end

	// ------------------------------------------------------------
	// Analog controls and interrupt outputs
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			CMP_ENABLE  <= 2'h0;
			CMP1_CHAN   <= 2'h0;
			CMP2_CHAN   <= 2'h0;
			CMP_REF_SEL <= 2'h0;
			TIMER_CMP   <= 1'b0;
			TIMER_LINK  <= 2'h0;
			IRQ         <= 1'b0;
			WAKE        <= 1'b0;
		end
		else
		begin
			CMP_ENABLE  <= {ctrl_q[1][`CMP_BIT_ON], ctrl_q[0][`CMP_BIT_ON]};
			CMP1_CHAN   <= ctrl_q[0][`CMP_CH_HI:`CMP_CH_LO];
			CMP2_CHAN   <= ctrl_q[1][`CMP_CH_HI:`CMP_CH_LO];
			CMP_REF_SEL <= {ctrl_q[1][`CMP_BIT_REF], ctrl_q[0][`CMP_BIT_REF]};
			TIMER_CMP   <= comparator_output[1];
			TIMER_LINK  <= ctrl2b_q[1:0];
			IRQ         <= gie_q & peripheral_irq_enable_q & |(flag_q & ien_q);
			WAKE        <= peripheral_irq_enable_q & |(flag_q & ien_q);
		end
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
			RDATA <= 8'h00;
		else if (RD)
		begin
			unique case (ADDR)
				`CMP_OFS_CTRL1:   RDATA <= {ctrl_q[0][7], comparator_output[0], ctrl_q[0][5:0]};
				`CMP_OFS_CTRL2:   RDATA <= {ctrl_q[1][7], comparator_output[1], ctrl_q[1][5:0]};
				`CMP_OFS_CTRL2B:  RDATA <= {comparator_output[0], comparator_output[1], 4'h0, ctrl2b_q[1:0]};
				`CMP_OFS_FLAGS:   RDATA <= {6'h00, flag_q};
				`CMP_OFS_ENABLES: RDATA <= {6'h00, ien_q};
				`CMP_OFS_IRQCTL:  RDATA <= {gie_q, peripheral_irq_enable_q, 6'h00};
				`CMP_OFS_PINDIR:  RDATA <= {6'h00, pindir_q};
				`CMP_OFS_PORTLAT: RDATA <= {6'h00, portlat_q};
				default:          RDATA <= 8'h00;
			endcase
		end
		else
			RDATA <= 8'h00;
	end

	// ------------------------------------------------------------
	// Checks: change detection
	// ------------------------------------------------------------
	a_flag_on_edge: assert property (@(posedge REF_CLK) disable iff (RST)
		(mismatch[0] && !mismatch_q[0]) |=> flag_q[0])
		else $error("flag not set on mismatch edge");

	a_flag_second: assert property (@(posedge REF_CLK) disable iff (RST)
		(mismatch[1] && !mismatch_q[1]) |=> flag_q[1])
		else $error("second flag not set on mismatch edge");

	a_read_clears: assert property (@(posedge REF_CLK) disable iff (RST)
		ctrl_touch[1] |=> snap_q[1] == $past(resample_q[1]))
		else $error("snapshot not refreshed");

	a_write_refresh: assert property (@(posedge REF_CLK) disable iff (RST)
		(WR && ADDR == `CMP_OFS_CTRL1) |=> snap_q[0] == $past(resample_q[0]))
		else $error("write did not refresh snapshot");

	a_snap_hold: assert property (@(posedge REF_CLK) disable iff (RST)
		!ctrl_touch[0] |=> $stable(snap_q[0]))
		else $error("snapshot moved without access");

	a_resample_phase: assert property (@(posedge REF_CLK) disable iff (RST)
		!first_clock_phase |=> $stable(resample_q))
		else $error("resample off phase");

	// A hardware set of the flag needs the two latches to disagree
	a_mismatch_xor: assert property (@(posedge REF_CLK) disable iff (RST)
		$rose(flag_q[0]) && !($past(WR) && $past(ADDR) == `CMP_OFS_FLAGS) |->
		$past(snap_q[0]) != $past(resample_q[0]))
		else $error("flag set without latch mismatch");

	a_flag_write: assert property (@(posedge REF_CLK) disable iff (RST)
		(WR && ADDR == `CMP_OFS_FLAGS && !(mismatch[0] && !mismatch_q[0])) |=> flag_q[0] == $past(WDATA[0]))
		else $error("flag write lost");

	a_irq_gated: assert property (@(posedge REF_CLK) disable iff (RST)
		IRQ |-> $past(gie_q) && $past(peripheral_irq_enable_q))
		else $error("irq without enables");

	a_irq_needs_ien: assert property (@(posedge REF_CLK) disable iff (RST)
		IRQ |-> |($past(flag_q) & $past(ien_q)))
		else $error("irq without enabled flag");

	a_wake_gated: assert property (@(posedge REF_CLK) disable iff (RST)
		WAKE |-> $past(peripheral_irq_enable_q) && |($past(flag_q) & $past(ien_q)))
		else $error("wake without enables");

	// ------------------------------------------------------------
	// Checks: pins and analog controls
	// ------------------------------------------------------------
	a_pin_off: assert property (@(posedge REF_CLK) disable iff (RST)
		!ctrl_q[0][`CMP_BIT_ON] && ctrl_q[0][`CMP_BIT_OE] |=> PIN_OE_N[0])
		else $error("pin driven while off");

	a_pin_dir: assert property (@(posedge REF_CLK) disable iff (RST)
		pindir_q[1] |=> PIN_OE_N[1])
		else $error("input pin driven");

	a_pin_latch: assert property (@(posedge REF_CLK) disable iff (RST)
		!ctrl_q[0][`CMP_BIT_OE] |=> PIN_OUT[0] == $past(portlat_q[0]))
		else $error("pin not from port latch");

	a_pin_result: assert property (@(posedge REF_CLK) disable iff (RST)
		ctrl_q[1][`CMP_BIT_OE] |=> PIN_OUT[1] == $past(result[1]))
		else $error("pin not from comparator");

	a_enable_out: assert property (@(posedge REF_CLK) disable iff (RST)
		1'b1 |=> CMP_ENABLE[0] == $past(ctrl_q[0][`CMP_BIT_ON]))
		else $error("enable output stale");

	a_timer_feed: assert property (@(posedge REF_CLK) disable iff (RST)
		1'b1 |=> TIMER_CMP == $past(resample_q[1]))
		else $error("timer feed not second comparator");

	// No disable here, so the check watches the reset itself
	a_reset_state: assert property (@(posedge REF_CLK)
		RST |=> (ctrl_q[0] == `CMP_CTRL_RST) && (ctrl_q[1] == `CMP_CTRL_RST) &&
		(ctrl2b_q == `CMP_CTRL2B_RST) && (CMP_ENABLE == 2'h0))
		else $error("reset state wrong");

	// ------------------------------------------------------------
	// Checks: read port
	// ------------------------------------------------------------
	a_mirror_read: assert property (@(posedge REF_CLK) disable iff (RST)
		(RD && ADDR == `CMP_OFS_CTRL2B) |=> RDATA[`CMP_BIT_MIR2] == $past(comparator_output[1]))
		else $error("mirror mismatch");

	a_mirror_first: assert property (@(posedge REF_CLK) disable iff (RST)
		(RD && ADDR == `CMP_OFS_CTRL2B) |=> RDATA[`CMP_BIT_MIR1] == $past(comparator_output[0]))
		else $error("first mirror mismatch");

	a_ctrl_out: assert property (@(posedge REF_CLK) disable iff (RST)
		(RD && ADDR == `CMP_OFS_CTRL1) |=> RDATA[`CMP_BIT_OUT] == $past(comparator_output[0]))
		else $error("control read output wrong");

	// Read data must not linger past their one cycle
	a_rdata_idle: assert property (@(posedge REF_CLK) disable iff (RST)
		!RD |=> RDATA == 8'h00)
		else $error("read data without read");
endmodule : cmp_ctrl

// ### cmp_ctrl_test.sv
// Self-checking testbench of the comparator control block
`timescale 1ns/10ps
`include "cmp_map.svh"

module cmp_ctrl_test;
	import cmp_pkg::*;

	localparam int PH = 4;

	logic           ref_clk;
	logic           rst;
	logic [3:0]     addr;
	byte_t          wdata;
	logic           wr_s;
	logic           rd_s;
	logic [7:0]     rdata;
	logic [1:0]     analog;
	logic [1:0]     cmp_en;
	chan_t          chan1;
	chan_t          chan2;
	logic [1:0]     ref_sel;
	logic [1:0]     pin_out;
	logic [1:0]     pin_oe_n;
	logic           timer_cmp;
	logic [1:0]     timer_link;
	logic           irq;
	logic           wake;
	int             err_count;
	int             checked;
	byte_t          d;

	cmp_ctrl #(.PHASE_COUNT(PH)) i_cmp_ctrl (
		.REF_CLK    (ref_clk),
		.RST        (rst),
		.ADDR       (addr),
		.WDATA      (wdata),
		.WR         (wr_s),
		.RD         (rd_s),
		.RDATA      (rdata),
		.ANALOG_CMP (analog),
		.CMP_ENABLE (cmp_en),
		.CMP1_CHAN  (chan1),
		.CMP2_CHAN  (chan2),
		.CMP_REF_SEL(ref_sel),
		.PIN_OUT    (pin_out),
		.PIN_OE_N   (pin_oe_n),
		.TIMER_CMP  (timer_cmp),
		.TIMER_LINK (timer_link),
		.IRQ        (irq),
		.WAKE       (wake)
	);

	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task wr(input logic [3:0] a, input byte_t v);
		@(posedge ref_clk);
		addr <= a;
		wdata <= v;
		wr_s <= 1'b1;
		@(posedge ref_clk);
		wr_s <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe; taken at the edge that closes it
	task rd(input logic [3:0] a, output byte_t v);
		@(posedge ref_clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge ref_clk);
		rd_s <= 1'b0;
		@(posedge ref_clk);
		v = rdata;
	endtask : rd

	// Up to one resample period, then mismatch, flag and output registers
	task settle;
		repeat (2 * PH) @(posedge ref_clk);
	endtask : settle

	task end_of_test;
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test

	task t_reset;
		rd(`CMP_OFS_CTRL1, d);
		chk(d, 8'h00);
		rd(`CMP_OFS_CTRL2B, d);
		chk(d, 8'h00);
		rd(4'hF, d);
		chk(d, 8'h00);
		chk({6'h00, pin_oe_n}, 8'h03);
		chk({6'h00, cmp_en}, 8'h00);
	endtask : t_reset

	task t_polarity;
		analog <= 2'b01;
		wr(`CMP_OFS_CTRL1, 8'h80);
		settle;
		rd(`CMP_OFS_CTRL1, d);
		chk(d, 8'hC0);
		rd(`CMP_OFS_CTRL2B, d);
		chk(d, 8'h80);
		wr(`CMP_OFS_CTRL1, 8'h90);
		settle;
		rd(`CMP_OFS_CTRL1, d);
		chk(d, 8'h90);
		wr(`CMP_OFS_CTRL1, 8'h40);
		settle;
		rd(`CMP_OFS_CTRL1, d);
		chk(d, 8'h00);
		chk({6'h00, cmp_en}, 8'h00);
	endtask : t_polarity

	task t_irq;
		wr(`CMP_OFS_ENABLES, 8'h01);
		wr(`CMP_OFS_IRQCTL, 8'hC0);
		wr(`CMP_OFS_CTRL1, 8'h80);
		settle;
		rd(`CMP_OFS_CTRL1, d);
		wr(`CMP_OFS_FLAGS, 8'h00);
		analog <= 2'b00;
		settle;
		rd(`CMP_OFS_FLAGS, d);
		chk(d & 8'h01, 8'h01);
		chk({7'h00, irq}, 8'h01);
		// Mismatch level still present, flag must stay clear
		wr(`CMP_OFS_FLAGS, 8'h00);
		settle;
		rd(`CMP_OFS_FLAGS, d);
		chk(d & 8'h01, 8'h00);
		rd(`CMP_OFS_CTRL1, d);
		chk(d, 8'h80);
		settle;
		rd(`CMP_OFS_FLAGS, d);
		chk(d & 8'h01, 8'h00);
		analog <= 2'b01;
		settle;
		rd(`CMP_OFS_FLAGS, d);
		chk(d & 8'h01, 8'h01);
		wr(`CMP_OFS_IRQCTL, 8'h40);
		settle;
		chk({6'h00, irq, wake}, 8'h01);
		wr(`CMP_OFS_FLAGS, 8'h00);
		settle;
		chk({6'h00, irq, wake}, 8'h00);
		wr(`CMP_OFS_FLAGS, 8'h01);
		rd(`CMP_OFS_FLAGS, d);
		chk(d & 8'h01, 8'h01);
		wr(`CMP_OFS_FLAGS, 8'h00);
	endtask : t_irq

	task t_pin;
		wr(`CMP_OFS_PORTLAT, 8'h01);
		wr(`CMP_OFS_PINDIR, 8'h00);
		analog <= 2'b11;
		wr(`CMP_OFS_CTRL1, 8'hB0);
		settle;
		chk({6'h00, pin_oe_n[0], pin_out[0]}, 8'h00);
		wr(`CMP_OFS_CTRL1, 8'hA0);
		settle;
		chk({6'h00, pin_oe_n[0], pin_out[0]}, 8'h01);
		// Override set while the comparator is off releases the pin, which is no longer driven
		wr(`CMP_OFS_CTRL1, 8'h20);
		settle;
		chk({6'h00, pin_oe_n[0], pin_out[0]}, 8'h02);
		wr(`CMP_OFS_CTRL1, 8'h00);
		settle;
		chk({6'h00, pin_oe_n[0], pin_out[0]}, 8'h01);
	endtask : t_pin

	task t_second;
		wr(`CMP_OFS_CTRL2, 8'h87);
		wr(`CMP_OFS_CTRL2B, 8'h02);
		settle;
		chk({cmp_en, chan2, ref_sel, 2'b00}, 8'hB8);
		chk({5'h00, timer_cmp, timer_link}, 8'h06);
		rd(`CMP_OFS_CTRL2B, d);
		chk(d, 8'h42);
		wr(`CMP_OFS_CTRL1, 8'h06);
		settle;
		chk({chan1, ref_sel, 4'h0}, 8'hB0);
		// Second comparator switched on with its input high has seen its own change
		rd(`CMP_OFS_FLAGS, d);
		chk(d & 8'h02, 8'h02);
		wr(`CMP_OFS_CTRL2, 8'hA0);
		settle;
		chk({6'h00, pin_oe_n[1], pin_out[1]}, 8'h01);
	endtask : t_second

	initial
	begin
		err_count = 0;
		checked = 0;
		rst = 1'b1;
		addr = 4'h0;
		wdata = 8'h00;
		wr_s = 1'b0;
		rd_s = 1'b0;
		analog = 2'b00;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset;
		t_polarity;
		t_irq;
		t_pin;
		t_second;
		end_of_test;
	end

	initial
	begin
		#20000;
		err_count++;
		end_of_test;
	end
endmodule : cmp_ctrl_test
